//--- nrr_pkg.sv
// shared constants and types for the suppressor ramp-rate register bank
package nrr_pkg;

   // register indices; byte address is four times the index
   localparam logic [5:0] IDX_ENG_LO_A = 6'h1a;
   localparam logic [5:0] IDX_ENG_HI_A = 6'h1b;
   localparam logic [5:0] IDX_REL_LO_A = 6'h1c;
   localparam logic [5:0] IDX_REL_HI_A = 6'h1d;
   localparam logic [5:0] IDX_STAT_A   = 6'h1e;
   localparam logic [5:0] IDX_ENG_LO_B = 6'h3a;
   localparam logic [5:0] IDX_ENG_HI_B = 6'h3b;
   localparam logic [5:0] IDX_REL_LO_B = 6'h3c;
   localparam logic [5:0] IDX_REL_HI_B = 6'h3d;
   localparam logic [5:0] IDX_STAT_B   = 6'h3e;

   // reset values of the rate bytes
   localparam logic [7:0] RST_ENG_LO = 8'h00;
   localparam logic [7:0] RST_ENG_HI = 8'h3e;
   localparam logic [7:0] RST_REL_LO = 8'h00;
   localparam logic [7:0] RST_REL_HI = 8'h41;

   // normalised unity and its fraction width
   localparam logic [15:0] UNITY  = 16'h4000;
   localparam int unsigned FRAC_W = 14;

   // status word field positions
   localparam int unsigned STAT_ENG_BAD_BIT = 16;
   localparam int unsigned STAT_REL_BAD_BIT = 17;

   // rate settings of one canceller
   typedef struct packed {
      logic [15:0] engage_rate;
      logic [15:0] release_rate;
   } nrr_rates_t;

   // state shown per canceller
   typedef struct packed {
      logic        release_invalid;
      logic        engage_invalid;
      logic [15:0] gain;
   } nrr_status_t;

endpackage

//--- nrr_regs.sv
// apb register bank and gain ramp of the residual suppressor rates
`timescale 1ns/100ps
`default_nettype none

// Functional notes
// - engage rate of each canceller scales suppressor gain; 4000 hex means one
// - smaller engage rate makes the suppressor engage faster
// - release rate of each canceller scales suppressor gain; 4000 hex means one
// - larger release rate makes the suppressor release faster
module nrr_regs #(
   parameter int unsigned ADDR_W = 8
) (
   input  wire logic                       pclk,
   input  wire logic                       presetn,
   input  wire logic                       psel,
   input  wire logic                       penable,
   input  wire logic                       pwrite,
   input  wire logic [ADDR_W-1:0]          paddr,
   input  wire logic [31:0]                pwdata,
   input  wire logic [3:0]                 pstrb,
   output var  logic [31:0]                prdata,
   output wire logic                       pready,
   output wire logic                       pslverr,
   input  wire logic                       sample_strobe,
   input  wire logic [1:0]                 suppress_request,
   output var  nrr_pkg::nrr_rates_t [1:0]  rate_setting,
   output var  logic [1:0][15:0]           suppressor_gain
);

   // ***************************************************************
   // elaboration checks
   // ***************************************************************
   if (ADDR_W < 8)
   begin : g_bad_addr
      $error("ADDR_W must be at least 8");
   end

   // ***************************************************************
   // apb decode
   // ***************************************************************
   logic [5:0]                 idx;
   logic                       mapped;
   logic                       setup_rd;
   logic                       wr_en;
   logic [31:0]                next_prdata;
   nrr_pkg::nrr_rates_t [1:0]  next_rate;
   nrr_pkg::nrr_status_t [1:0] status;

   assign idx = paddr[7:2];

   // byte address must be word aligned and hit a listed index
   always_comb
   begin
      mapped = 1'b0;
      if (paddr[1:0] == 2'b00 && (paddr >> 8) == '0)
      begin
         unique case (idx)
            nrr_pkg::IDX_ENG_LO_A, nrr_pkg::IDX_ENG_HI_A,
            nrr_pkg::IDX_REL_LO_A, nrr_pkg::IDX_REL_HI_A,
            nrr_pkg::IDX_STAT_A,   nrr_pkg::IDX_ENG_LO_B,
            nrr_pkg::IDX_ENG_HI_B, nrr_pkg::IDX_REL_LO_B,
            nrr_pkg::IDX_REL_HI_B, nrr_pkg::IDX_STAT_B: mapped = 1'b1;
            default:                                   mapped = 1'b0;
         endcase
      end
   end

   // zero wait states; error only on unmapped access phase
   assign pready   = 1'b1;
   assign pslverr  = psel & penable & ~mapped;
   assign setup_rd = psel & ~penable & ~pwrite;
   assign wr_en    = psel & penable & pwrite & mapped & pstrb[0];

   // ***************************************************************
   // rate registers
   // ***************************************************************
   // byte writes land only in the addressed canceller's halves
   always_comb
   begin
      next_rate = rate_setting;
      if (wr_en)
      begin
         unique case (idx)
            nrr_pkg::IDX_ENG_LO_A: next_rate[0].engage_rate[7:0]   = pwdata[7:0];
            nrr_pkg::IDX_ENG_HI_A: next_rate[0].engage_rate[15:8]  = pwdata[7:0];
            nrr_pkg::IDX_REL_LO_A: next_rate[0].release_rate[7:0]  = pwdata[7:0];
            nrr_pkg::IDX_REL_HI_A: next_rate[0].release_rate[15:8] = pwdata[7:0];
            nrr_pkg::IDX_ENG_LO_B: next_rate[1].engage_rate[7:0]   = pwdata[7:0];
            nrr_pkg::IDX_ENG_HI_B: next_rate[1].engage_rate[15:8]  = pwdata[7:0];
            nrr_pkg::IDX_REL_LO_B: next_rate[1].release_rate[7:0]  = pwdata[7:0];
            nrr_pkg::IDX_REL_HI_B: next_rate[1].release_rate[15:8] = pwdata[7:0];
            default:               next_rate = rate_setting;  // status is read only
         endcase
      end
   end

   // register the rate settings
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         for (int c = 0; c < 2; c++)
         begin
            rate_setting[c].engage_rate  <= {nrr_pkg::RST_ENG_HI, nrr_pkg::RST_ENG_LO};
            rate_setting[c].release_rate <= {nrr_pkg::RST_REL_HI, nrr_pkg::RST_REL_LO};
         end
      end
      else
      begin
         rate_setting <= next_rate;
      end
   end

   // ***************************************************************
   // read data
   // ***************************************************************
   // loaded in the setup cycle so it is stable through the access phase
   always_comb
   begin
      next_prdata = prdata;
      if (setup_rd && !mapped)
      begin
         next_prdata = 32'h0;  // unmapped or misaligned reads answer zero
      end
      else if (setup_rd)
      begin
         unique case (idx)
            nrr_pkg::IDX_ENG_LO_A: next_prdata = {24'h0, rate_setting[0].engage_rate[7:0]};
            nrr_pkg::IDX_ENG_HI_A: next_prdata = {24'h0, rate_setting[0].engage_rate[15:8]};
            nrr_pkg::IDX_REL_LO_A: next_prdata = {24'h0, rate_setting[0].release_rate[7:0]};
            nrr_pkg::IDX_REL_HI_A: next_prdata = {24'h0, rate_setting[0].release_rate[15:8]};
            nrr_pkg::IDX_STAT_A:   next_prdata = {14'h0, status[0]};
            nrr_pkg::IDX_ENG_LO_B: next_prdata = {24'h0, rate_setting[1].engage_rate[7:0]};
            nrr_pkg::IDX_ENG_HI_B: next_prdata = {24'h0, rate_setting[1].engage_rate[15:8]};
            nrr_pkg::IDX_REL_LO_B: next_prdata = {24'h0, rate_setting[1].release_rate[7:0]};
            nrr_pkg::IDX_REL_HI_B: next_prdata = {24'h0, rate_setting[1].release_rate[15:8]};
            nrr_pkg::IDX_STAT_B:   next_prdata = {14'h0, status[1]};
            default:               next_prdata = 32'h0;
         endcase
      end
   end

   // register the read data
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata <= 32'h0;
      end
      else
      begin
         prdata <= next_prdata;
      end
   end

   // ***************************************************************
   // per canceller gain ramp
   // ***************************************************************
   for (genvar c = 0; c < 2; c++)
   begin : g_ch
      logic        engage_ok;
      logic        release_ok;
      logic [31:0] eng_prod;
      logic [31:0] rel_prod;
      logic [17:0] rel_cand;
      logic [15:0] next_gain;

      // settings outside the valid side of unity freeze the ramp
      assign engage_ok  = rate_setting[c].engage_rate < nrr_pkg::UNITY;
      assign release_ok = rate_setting[c].release_rate > nrr_pkg::UNITY;
      assign status[c]  = '{release_invalid: ~release_ok,
                            engage_invalid:  ~engage_ok,
                            gain:            suppressor_gain[c]};

      // gain times rate over unity, once per sample
      always_comb
      begin
         eng_prod  = 32'(suppressor_gain[c]) * 32'(rate_setting[c].engage_rate);
         rel_prod  = 32'(suppressor_gain[c]) * 32'(rate_setting[c].release_rate);
         rel_cand  = rel_prod[31:nrr_pkg::FRAC_W];
         next_gain = suppressor_gain[c];
         if (sample_strobe && suppress_request[c] && engage_ok)
         begin
            next_gain = eng_prod[nrr_pkg::FRAC_W +: 16];
         end
         else if (sample_strobe && !suppress_request[c] && release_ok)
         begin
            // a tiny gain must still climb off zero
            if (rel_cand <= 18'(suppressor_gain[c]))
            begin
               rel_cand = 18'(suppressor_gain[c]) + 18'h1;
            end
            if (rel_cand > 18'(nrr_pkg::UNITY))
            begin
               rel_cand = 18'(nrr_pkg::UNITY);
            end
            next_gain = rel_cand[15:0];
         end
      end

      // suppressor starts released at unity gain
      always_ff @(posedge pclk or negedge presetn)
      begin
         if (!presetn)
         begin
            suppressor_gain[c] <= nrr_pkg::UNITY;
         end
         else
         begin
            suppressor_gain[c] <= next_gain;
         end
      end

      // ------------------------------------------------------------
      // checks
      // ------------------------------------------------------------
      sequence engage_step_s;
         sample_strobe && suppress_request[c] && engage_ok;
      endsequence

      sequence release_step_s;
         sample_strobe && !suppress_request[c] && release_ok
            && suppressor_gain[c] < nrr_pkg::UNITY;
      endsequence

      sequence foreign_write_s;
         psel && penable && pwrite && paddr[7] != 1'(c);
      endsequence

      engage_value_a: assert property (@(posedge pclk) disable iff (!presetn)
         engage_step_s |=> suppressor_gain[c] ==
            16'((32'($past(suppressor_gain[c]))
                 * 32'($past(rate_setting[c].engage_rate))) >> nrr_pkg::FRAC_W))
         else $error("engage gain not gain times rate over unity");

      engage_falls_a: assert property (@(posedge pclk) disable iff (!presetn)
         engage_step_s ##0 (suppressor_gain[c] != 16'h0) |=>
            suppressor_gain[c] < $past(suppressor_gain[c]))
         else $error("gain did not fall while engaging");

      release_rises_a: assert property (@(posedge pclk) disable iff (!presetn)
         release_step_s |=> suppressor_gain[c] > $past(suppressor_gain[c]))
         else $error("gain did not rise while releasing");

      gain_capped_a: assert property (@(posedge pclk) disable iff (!presetn)
         suppressor_gain[c] <= nrr_pkg::UNITY)
         else $error("gain above unity");

      idle_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
         !sample_strobe |=> $stable(suppressor_gain[c]))
         else $error("gain moved without a sample strobe");

      own_rates_a: assert property (@(posedge pclk) disable iff (!presetn)
         foreign_write_s |=> $stable(rate_setting[c]))
         else $error("write to other canceller changed this rate");

      // an invalid engage rate freezes the gain
      engage_frozen_a: assert property (@(posedge pclk) disable iff (!presetn)
         sample_strobe && suppress_request[c] && !engage_ok |=> $stable(suppressor_gain[c]))
         else $error("gain moved under an invalid engage rate");

      // an invalid release rate freezes the gain
      release_frozen_a: assert property (@(posedge pclk) disable iff (!presetn)
         sample_strobe && !suppress_request[c] && !release_ok |=> $stable(suppressor_gain[c]))
         else $error("gain moved under an invalid release rate");
   end

   // ***************************************************************
   // bus checks
   // ***************************************************************
   // a write lands in the addressed byte at its access edge
   eng_low_write_a: assert property (@(posedge pclk) disable iff (!presetn)
      wr_en && idx == nrr_pkg::IDX_ENG_LO_A |=>
         rate_setting[0].engage_rate[7:0] == $past(pwdata[7:0]))
      else $error("engage low byte of canceller a not written");

   // the same for the release high byte of canceller b
   rel_high_write_a: assert property (@(posedge pclk) disable iff (!presetn)
      wr_en && idx == nrr_pkg::IDX_REL_HI_B |=>
         rate_setting[1].release_rate[15:8] == $past(pwdata[7:0]))
      else $error("release high byte of canceller b not written");

   // a refused read answers zero with an error
   unmapped_read_a: assert property (@(posedge pclk) disable iff (!presetn)
      psel && penable && !pwrite && !mapped |-> pslverr && prdata == 32'h0)
      else $error("refused read did not answer zero with an error");

   // a write without the low byte strobe changes nothing
   strobe_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
      psel && penable && pwrite && !pstrb[0] |=> $stable(rate_setting))
      else $error("write without byte strobe changed a rate");

   // a refused write raises the error and changes nothing
   unmapped_write_a: assert property (@(posedge pclk) disable iff (!presetn)
      psel && penable && pwrite && !mapped |-> pslverr ##1 $stable(rate_setting))
      else $error("refused write changed a rate");

endmodule // nrr_regs

`default_nettype wire

//--- nlp_ramp_rate_registers_test.sv
// self-checking testbench of the suppressor ramp-rate register bank
`timescale 1ns/100ps
`default_nettype none

module nlp_ramp_rate_registers_test;
   logic                      pclk = 1'b0;
   logic                      presetn = 1'b0;
   logic                      psel = 1'b0;
   logic                      penable = 1'b0;
   logic                      pwrite = 1'b0;
   logic                      sample_strobe = 1'b0;
   logic [7:0]                paddr = 8'h00;
   logic [31:0]               pwdata = 32'h0000_0000;
   logic [3:0]                pstrb = 4'hf;
   logic [1:0]                suppress_request = 2'h0;
   logic [31:0]               prdata;
   wire logic                 pready;
   wire logic                 pslverr;
   nrr_pkg::nrr_rates_t [1:0] rate_setting;
   logic [1:0][15:0]          suppressor_gain;
   int                        err_total = 0;
   int                        compares = 0;
   int                        seed = 32'h3cba;
   logic [32:0]               exp_q[$];
   logic [31:0]               gain_q[$];
   logic [31:0]               exp_gain;
   logic                      strobe_seen = 1'b0;
   logic [5:0]                idx_tab[8] = '{nrr_pkg::IDX_ENG_LO_A, nrr_pkg::IDX_ENG_HI_A,
      nrr_pkg::IDX_REL_LO_A, nrr_pkg::IDX_REL_HI_A, nrr_pkg::IDX_ENG_LO_B,
      nrr_pkg::IDX_ENG_HI_B, nrr_pkg::IDX_REL_LO_B, nrr_pkg::IDX_REL_HI_B};
   logic [7:0]                val[8] = '{8'h00, 8'h3e, 8'h00, 8'h41, 8'h00, 8'h3e, 8'h00, 8'h41};

   nrr_regs nrr_regs_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .sample_strobe(sample_strobe),
      .suppress_request(suppress_request), .rate_setting(rate_setting),
      .suppressor_gain(suppressor_gain));

   // 50 mhz clock
   always #10 pclk = ~pclk;

   // compare one value and count it
   task automatic check(input logic [32:0] seen, input logic [32:0] want);
      compares++;
      if (seen !== want)
      begin
         err_total++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, want);
      end
   endtask

   // one apb transfer; a read notes {pslverr, prdata} in the queue
   task automatic apb(input logic wr, input logic [5:0] idx, input logic [31:0] d,
                      input logic [32:0] want);
      if (!wr)
         exp_q.push_back(want);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {idx, 2'b00};
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   // one sample strobe; expected gains noted for the gain watcher
   task automatic strobe(input logic [1:0] req, input logic [15:0] ga, input logic [15:0] gb);
      gain_q.push_back({gb, ga});
      sample_strobe <= 1'b1;
      suppress_request <= req;
      @(posedge pclk);
      sample_strobe <= 1'b0;
      @(posedge pclk);
   endtask

   // gain watcher: takes the oldest note one edge after each strobe
   always @(posedge pclk)
   begin
      if (strobe_seen)
      begin
         exp_gain = gain_q.pop_front();
         check({17'h0, suppressor_gain[0]}, {17'h0, exp_gain[15:0]});
         check({17'h0, suppressor_gain[1]}, {17'h0, exp_gain[31:16]});
      end
      strobe_seen <= sample_strobe;
   end

   // read watcher: takes the oldest note at each completed read
   always @(posedge pclk)
   begin
      if (psel && penable && pready && !pwrite)
         check({pslverr, prdata}, exp_q.pop_front());
   end

   // verdict and end of run
   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", compares, err_total);
      if (err_total == 0 && compares > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // watchdog against a hang
   initial
   begin
      repeat (4000) @(posedge pclk);
      err_total++;
      complete_run();
   end

   // ***************************************************************
   // main sequence
   // ***************************************************************
   initial
   begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      check({1'b0, rate_setting[1]}, 33'h0_3e00_4100);
      for (int i = 0; i < 8; i++)
         apb(1'b0, idx_tab[i], 32'h0, {25'h0, val[i]});
      apb(1'b0, nrr_pkg::IDX_STAT_A, 32'h0, 33'h0_0000_4000);
      $display("reset values done");
      for (int i = 0; i < 8; i++)
      begin
         val[i] = 8'($random(seed));
         apb(1'b1, idx_tab[i], {24'h0, val[i]}, 33'h0);
      end
      for (int i = 0; i < 8; i++)
         apb(1'b0, idx_tab[i], 32'h0, {25'h0, val[i]});
      check({1'b0, rate_setting[0]}, {1'b0, val[1], val[0], val[3], val[2]});
      check({1'b0, rate_setting[1]}, {1'b0, val[5], val[4], val[7], val[6]});
      pstrb <= 4'he;
      apb(1'b1, nrr_pkg::IDX_ENG_LO_A, ~{24'h0, val[0]}, 33'h0);
      pstrb <= 4'hf;
      apb(1'b0, nrr_pkg::IDX_ENG_LO_A, 32'h0, {25'h0, val[0]});
      apb(1'b1, 6'h00, 32'h0000_00aa, 33'h0);
      apb(1'b0, 6'h00, 32'h0, 33'h1_0000_0000);
      $display("readback and unmapped done");
      // canceller a: engage 2000, release 8000; canceller b: 3e00, 4100
      val = '{8'h00, 8'h20, 8'h00, 8'h80, 8'h00, 8'h3e, 8'h00, 8'h41};
      for (int i = 0; i < 8; i++)
         apb(1'b1, idx_tab[i], {24'h0, val[i]}, 33'h0);
      strobe(2'b01, 16'h2000, 16'h4000);
      strobe(2'b01, 16'h1000, 16'h4000);
      apb(1'b1, nrr_pkg::IDX_ENG_HI_A, 32'h0000_0040, 33'h0);
      strobe(2'b01, 16'h1000, 16'h4000);
      apb(1'b0, nrr_pkg::IDX_STAT_A, 32'h0, 33'h0_0001_1000);
      strobe(2'b10, 16'h2000, 16'h3e00);
      strobe(2'b10, 16'h4000, 16'h3c10);
      apb(1'b1, nrr_pkg::IDX_REL_HI_B, 32'h0000_0040, 33'h0);
      strobe(2'b00, 16'h4000, 16'h3c10);
      apb(1'b0, nrr_pkg::IDX_STAT_B, 32'h0, 33'h0_0002_3c10);
      $display("ramp tests done");
      complete_run();
   end
endmodule // nlp_ramp_rate_registers_test

`default_nettype wire
